//--- hdl/standby_pin_pkg.sv
package standby_pin_pkg;

    // core clock
    localparam int unsigned CLK_HZ = 40_000_000;

    // blink time base: half period of the 1 Hz square wave
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned BLINK_CNT_W = 25;

    // apb geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // register indexes, byte address is four times the index
    localparam logic [7:0] IDX_ACTIVATION = 8'h30;
    localparam logic [7:0] IDX_SUSPEND_MODE = 8'hF3;
    localparam logic [7:0] IDX_FUNC_SELECT = 8'hF7;
    // per group, packed as {d, c, b, a}
    localparam logic [3:0][7:0] IDX_DIR = {8'hE0, 8'hF4, 8'hF0, 8'hE3};
    localparam logic [3:0][7:0] IDX_DATA = {8'hE1, 8'hF5, 8'hF1, 8'hE4};
    localparam logic [3:0][7:0] IDX_INV = {8'hE2, 8'hF6, 8'hF2, 8'hE5};

    // group numbering
    localparam int unsigned GRP_A = 0;
    localparam int unsigned GRP_B = 1;
    localparam int unsigned GRP_C = 2;
    localparam int unsigned GRP_D = 3;
    localparam int unsigned NUM_GRP = 4;

    // field positions
    localparam int unsigned ACT_W = 4;
    localparam int unsigned MODE_LSB = 6;

    // values after reset
    localparam logic [3:0] ACT_RESET = 4'h0;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] INV_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] FSEL_RESET = 8'h00;

    // suspend indicator modes
    localparam logic [1:0] MODE_TRISTATE = 2'h0;
    localparam logic [1:0] MODE_LOW = 2'h1;
    localparam logic [1:0] MODE_BLINK_1HZ = 2'h2;
    localparam logic [1:0] MODE_BLINK_QUARTER = 2'h3;

endpackage

//--- hdl/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
    parameter int unsigned WIDTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] synced
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // first stage feeds only the second
    always_comb begin
        next_st = st;
        next_st.first = raw;
        next_st.second = st.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign synced = st.second;

endmodule

//--- hdl/blink_base.sv
`timescale 1ns/1ps

module blink_base #(
    parameter int unsigned HALF_CYCLES = standby_pin_pkg::BLINK_HALF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic blink_1hz,
    output logic blink_quarter_hz
);

    localparam int unsigned CW = standby_pin_pkg::BLINK_CNT_W;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [2:0] phase;
    } blink_s;

    blink_s st;
    blink_s next_st;

    // divide slow base: phase[0] is 1 hz, phase[2] is a quarter hz
    always_comb begin
        next_st = st;
        if (st.cnt == CW'(HALF_CYCLES - 1)) begin
            next_st.cnt = '0;
            next_st.phase = st.phase + 3'h1;
        end else begin
            next_st.cnt = st.cnt + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign blink_1hz = st.phase[0];
    assign blink_quarter_hz = st.phase[2];

    AST_QUARTER_FROM_BASE: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(st.phase[2]) |-> $changed(st.phase[0]) && !st.phase[1] && !st.phase[0])
        else $error("quarter hz edge without matching 1 hz edge");

endmodule

//--- hdl/standby_pin_groups_led.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module standby_pin_groups_led #(
    parameter int unsigned BLINK_HALF_CYCLES = standby_pin_pkg::BLINK_HALF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_group_a_in,
    output logic [7:0] pin_group_a_out,
    output logic [7:0] pin_group_a_oe_n,
    input wire logic [7:0] pin_group_b_in,
    output logic [7:0] pin_group_b_out,
    output logic [7:0] pin_group_b_oe_n,
    input wire logic [7:0] pin_group_c_in,
    output logic [7:0] pin_group_c_out,
    output logic [7:0] pin_group_c_oe_n,
    input wire logic [7:0] pin_group_d_in,
    output logic [7:0] pin_group_d_out,
    output logic [7:0] pin_group_d_oe_n,
    output logic suspend_indicator_out,
    output logic suspend_indicator_oe_n,
    input wire logic watchdog_timeout_n
);

    typedef struct packed {
        logic [3:0] active;
        logic [3:0][7:0] dir;
        logic [3:0][7:0] data;
        logic [3:0][7:0] inv;
        logic [1:0] mode;
        logic [7:0] fsel;
        logic [31:0] rdata;
        logic [3:0][7:0] pin_out;
        logic [3:0][7:0] pin_oe_n;
        logic led_out;
        logic led_oe_n;
    } state_s;

    state_s st;
    state_s next_st;

    logic [31:0] pin_raw;
    logic [31:0] pin_sync_flat;
    logic [3:0][7:0] pin_sync;
    logic blink_1hz;
    logic blink_quarter_hz;
    logic [3:0][7:0] drive_out;
    logic [3:0][7:0] drive_oe_n;
    logic [3:0][7:0] data_view;
    logic [7:0] addr_idx;
    logic addr_ok;
    logic hit;
    logic [31:0] rd_val;
    logic wr_en;

    // pins cross into the core clock
    assign pin_raw = {pin_group_d_in, pin_group_c_in, pin_group_b_in, pin_group_a_in};

    pin_sync #(
        .WIDTH(32)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw(pin_raw),
        .synced(pin_sync_flat)
    );

    assign pin_sync = pin_sync_flat;

    blink_base #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink_base (
        .pclk(pclk),
        .presetn(presetn),
        .blink_1hz(blink_1hz),
        .blink_quarter_hz(blink_quarter_hz)
    );

    // per group pin drive and data view
    for (genvar g = 0; g < standby_pin_pkg::NUM_GRP; g++) begin : g_group
        // stored bit for outputs, pin for inputs
        assign data_view[g] = (st.data[g] & ~st.dir[g])
            | ((pin_sync[g] ^ st.inv[g]) & st.dir[g]);
        // drive outputs only when the group is active
        assign drive_out[g] = st.data[g] ^ st.inv[g];
        assign drive_oe_n[g] = st.dir[g] | {8{~st.active[g]}};
    end

    // apb decode
    assign addr_idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign wr_en = psel && penable && pwrite && hit && pstrb[0];

    always_comb begin
        hit = 1'b0;
        rd_val = 32'h0000_0000;
        if (addr_ok) begin
            if (addr_idx == standby_pin_pkg::IDX_ACTIVATION) begin
                hit = 1'b1;
                rd_val[standby_pin_pkg::ACT_W-1:0] = st.active;
            end
            if (addr_idx == standby_pin_pkg::IDX_SUSPEND_MODE) begin
                hit = 1'b1;
                rd_val[standby_pin_pkg::MODE_LSB +: 2] = st.mode;
            end
            if (addr_idx == standby_pin_pkg::IDX_FUNC_SELECT) begin
                hit = 1'b1;
                rd_val[7:0] = st.fsel;
            end
            for (int g = 0; g < standby_pin_pkg::NUM_GRP; g++) begin
                if (addr_idx == standby_pin_pkg::IDX_DIR[g]) begin
                    hit = 1'b1;
                    rd_val[7:0] = st.dir[g];
                end
                if (addr_idx == standby_pin_pkg::IDX_DATA[g]) begin
                    hit = 1'b1;
                    rd_val[7:0] = data_view[g];
                end
                if (addr_idx == standby_pin_pkg::IDX_INV[g]) begin
                    hit = 1'b1;
                    rd_val[7:0] = st.inv[g];
                end
            end
        end
    end

    // next state
    always_comb begin
        next_st = st;
        // read data captured in setup phase
        if (psel && !penable) begin
            next_st.rdata = rd_val;
        end
        if (wr_en) begin
            if (addr_idx == standby_pin_pkg::IDX_ACTIVATION) begin
                next_st.active = pwdata[standby_pin_pkg::ACT_W-1:0];
            end
            if (addr_idx == standby_pin_pkg::IDX_SUSPEND_MODE) begin
                next_st.mode = pwdata[standby_pin_pkg::MODE_LSB +: 2];
            end
            if (addr_idx == standby_pin_pkg::IDX_FUNC_SELECT) begin
                next_st.fsel = pwdata[7:0];
            end
            for (int g = 0; g < standby_pin_pkg::NUM_GRP; g++) begin
                if (addr_idx == standby_pin_pkg::IDX_DIR[g]) begin
                    next_st.dir[g] = pwdata[7:0];
                end
                if (addr_idx == standby_pin_pkg::IDX_DATA[g]) begin
                    next_st.data[g] = (st.data[g] & st.dir[g])
                        | (pwdata[7:0] & ~st.dir[g]);
                end
                if (addr_idx == standby_pin_pkg::IDX_INV[g]) begin
                    next_st.inv[g] = pwdata[7:0];
                end
            end
        end
        // suspend indicator
        case (st.mode)
            standby_pin_pkg::MODE_TRISTATE: begin
                next_st.led_out = 1'b0;
                next_st.led_oe_n = 1'b1;
            end
            standby_pin_pkg::MODE_LOW: begin
                next_st.led_out = 1'b0;
                next_st.led_oe_n = 1'b0;
            end
            standby_pin_pkg::MODE_BLINK_1HZ: begin
                next_st.led_out = blink_1hz;
                next_st.led_oe_n = 1'b0;
            end
            standby_pin_pkg::MODE_BLINK_QUARTER: begin
                next_st.led_out = blink_quarter_hz;
                next_st.led_oe_n = 1'b0;
            end
            default: begin
                next_st.led_out = 1'b0;
                next_st.led_oe_n = 1'b1;
            end
        endcase
        // pin drive, group c alternate functions override
        next_st.pin_out = drive_out;
        next_st.pin_oe_n = drive_oe_n;
        for (int b = 0; b < 8; b++) begin
            if (st.fsel[b]) begin
                if ((b % 2) == 0) begin
                    next_st.pin_out[standby_pin_pkg::GRP_C][b] = watchdog_timeout_n;
                    next_st.pin_oe_n[standby_pin_pkg::GRP_C][b] = 1'b0;
                end else begin
                    next_st.pin_out[standby_pin_pkg::GRP_C][b] = st.led_out;
                    next_st.pin_oe_n[standby_pin_pkg::GRP_C][b] = st.led_oe_n;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.active <= standby_pin_pkg::ACT_RESET;
            st.dir <= {4{standby_pin_pkg::DIR_RESET}};
            st.data <= {4{standby_pin_pkg::DATA_RESET}};
            st.inv <= {4{standby_pin_pkg::INV_RESET}};
            st.mode <= standby_pin_pkg::MODE_RESET;
            st.fsel <= standby_pin_pkg::FSEL_RESET;
            st.rdata <= 32'h0000_0000;
            st.pin_out <= '0;
            st.pin_oe_n <= '1;
            st.led_out <= 1'b0;
            st.led_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign pin_group_a_out = st.pin_out[standby_pin_pkg::GRP_A];
    assign pin_group_a_oe_n = st.pin_oe_n[standby_pin_pkg::GRP_A];
    assign pin_group_b_out = st.pin_out[standby_pin_pkg::GRP_B];
    assign pin_group_b_oe_n = st.pin_oe_n[standby_pin_pkg::GRP_B];
    assign pin_group_c_out = st.pin_out[standby_pin_pkg::GRP_C];
    assign pin_group_c_oe_n = st.pin_oe_n[standby_pin_pkg::GRP_C];
    assign pin_group_d_out = st.pin_out[standby_pin_pkg::GRP_D];
    assign pin_group_d_oe_n = st.pin_oe_n[standby_pin_pkg::GRP_D];
    assign suspend_indicator_out = st.led_out;
    assign suspend_indicator_oe_n = st.led_oe_n;

    // checks
    AST_ACT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && addr_idx == standby_pin_pkg::IDX_ACTIVATION
        |=> st.active == $past(pwdata[3:0]))
        else $error("activation bits not taken from write");

    AST_INACTIVE_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
        !st.active[0] |=> pin_group_a_oe_n == 8'hFF)
        else $error("inactive group a drives a pin");

    AST_OUTPUT_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
        st.active[3] && !st.dir[3][5] |=> !pin_group_d_oe_n[5])
        else $error("output pin of group d not driven");

    AST_OUTPUT_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
        st.active[1] && !st.dir[1][0]
        |=> pin_group_b_out[0] == $past(st.data[1][0] ^ st.inv[1][0]))
        else $error("group b pin value does not follow data and inversion");

    AST_INPUT_WRITE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && addr_idx == standby_pin_pkg::IDX_DATA[0] && st.dir[0] == 8'hFF
        |=> $stable(st.data[0]))
        else $error("write changed data of input pins");

    AST_INPUT_READ: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && addr_ok && addr_idx == standby_pin_pkg::IDX_DATA[3]
        && st.dir[3] == 8'hFF
        |=> prdata[7:0] == $past(pin_sync[3] ^ st.inv[3]))
        else $error("input read does not return inverted pin state");

    AST_LED_TRISTATE: assert property (@(posedge pclk) disable iff (!presetn)
        st.mode == standby_pin_pkg::MODE_TRISTATE |=> suspend_indicator_oe_n)
        else $error("suspend indicator driven in tri-state mode");

    AST_LED_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        st.mode == standby_pin_pkg::MODE_LOW
        |=> !suspend_indicator_oe_n && !suspend_indicator_out)
        else $error("suspend indicator not driven low");

    AST_LED_BLINK: assert property (@(posedge pclk) disable iff (!presetn)
        st.mode == standby_pin_pkg::MODE_BLINK_QUARTER
        |=> suspend_indicator_out == $past(blink_quarter_hz))
        else $error("suspend indicator not following quarter hz base");

    AST_WATCHDOG_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        st.fsel[2] |=> !pin_group_c_oe_n[2] && pin_group_c_out[2] == $past(watchdog_timeout_n))
        else $error("group c pin 2 not carrying watchdog output");

    AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h000000
        && !(st.rdata[5:0] != 6'h00 && $past(addr_idx) == standby_pin_pkg::IDX_SUSPEND_MODE
        && $past(psel && !penable && addr_ok)))
        else $error("reserved bits read non-zero");

endmodule

//--- bench/standby_pin_groups_led_test.sv
`timescale 1ns/1ps

module standby_pin_groups_led_test;
    localparam int unsigned HALF = 8;
    logic pclk;
    logic presetn;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_in [4];
    logic [7:0] pin_out [4];
    logic [7:0] pin_oe_n [4];
    logic led_out;
    logic led_oe_n;
    logic watchdog_timeout_n;
    int failures;
    int samples_checked;
    int seed;
    logic [7:0] stored [4];
    logic [31:0] rd;
    logic err;
    logic [3:0] strb_sel;

    standby_pin_groups_led #(.BLINK_HALF_CYCLES(HALF)) uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr),
        .pin_group_a_in(pin_in[0]), .pin_group_a_out(pin_out[0]), .pin_group_a_oe_n(pin_oe_n[0]),
        .pin_group_b_in(pin_in[1]), .pin_group_b_out(pin_out[1]), .pin_group_b_oe_n(pin_oe_n[1]),
        .pin_group_c_in(pin_in[2]), .pin_group_c_out(pin_out[2]), .pin_group_c_oe_n(pin_oe_n[2]),
        .pin_group_d_in(pin_in[3]), .pin_group_d_out(pin_out[3]), .pin_group_d_oe_n(pin_oe_n[3]),
        .suspend_indicator_out(led_out), .suspend_indicator_oe_n(led_oe_n),
        .watchdog_timeout_n(watchdog_timeout_n)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= {24'h0, d};
        pstrb <= strb_sel;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            chk("pready", 1, 0);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, ba(idx), 8'h00);
        chk(nm, {24'h0, exp}, rd);
        chk("pslverr", 0, err);
    endtask

    task automatic check_reset_values();
        rdchk("activation", standby_pin_pkg::IDX_ACTIVATION, 8'h00);
        rdchk("mode", standby_pin_pkg::IDX_SUSPEND_MODE, 8'h00);
        rdchk("func select", standby_pin_pkg::IDX_FUNC_SELECT, 8'h00);
        for (int g = 0; g < 4; g++) begin
            rdchk("direction", standby_pin_pkg::IDX_DIR[g], 8'hFF);
            rdchk("data", standby_pin_pkg::IDX_DATA[g], 8'h00);
            rdchk("inversion", standby_pin_pkg::IDX_INV[g], 8'h00);
            chk("oe_n", 8'hFF, pin_oe_n[g]);
        end
        chk("led oe_n", 1, led_oe_n);
    endtask

    task automatic rand_step();
        int g;
        logic [7:0] act;
        logic [7:0] dir;
        logic [7:0] inv;
        logic [7:0] d;
        logic [7:0] pin;
        g = {$random(seed)} % 4;
        act = 8'($random(seed));
        dir = 8'($random(seed));
        inv = 8'($random(seed));
        d = 8'($random(seed));
        pin = 8'($random(seed));
        pin_in[g] <= pin;
        apb(1'b1, ba(standby_pin_pkg::IDX_ACTIVATION), act);
        apb(1'b1, ba(standby_pin_pkg::IDX_DIR[g]), dir);
        apb(1'b1, ba(standby_pin_pkg::IDX_INV[g]), inv);
        apb(1'b1, ba(standby_pin_pkg::IDX_DATA[g]), d);
        stored[g] = (stored[g] & dir) | (d & ~dir);
        repeat (3) @(posedge pclk);
        rdchk("activation", standby_pin_pkg::IDX_ACTIVATION, {4'h0, act[3:0]});
        rdchk("direction", standby_pin_pkg::IDX_DIR[g], dir);
        rdchk("inversion", standby_pin_pkg::IDX_INV[g], inv);
        rdchk("data", standby_pin_pkg::IDX_DATA[g], (stored[g] & ~dir) | ((pin ^ inv) & dir));
        chk("oe_n", act[g] ? dir : 8'hFF, pin_oe_n[g]);
        if (act[g]) begin
            chk("pin out", (stored[g] ^ inv) & ~dir, pin_out[g] & ~dir);
        end
    endtask

    // lengths of two consecutive levels of the indicator
    task automatic levels(output int n1, output int n2);
        logic v;
        int k;
        k = 0;
        @(posedge pclk);
        v = led_out;
        while (led_out === v && k < 200) begin
            @(posedge pclk);
            k++;
        end
        v = led_out;
        n1 = 0;
        while (led_out === v && n1 < 200) begin
            @(posedge pclk);
            n1++;
        end
        v = led_out;
        n2 = 0;
        while (led_out === v && n2 < 200) begin
            @(posedge pclk);
            n2++;
        end
    endtask

    initial begin
        repeat (50000) @(posedge pclk);
        $display("CHECK FAILED watchdog expected finish seen timeout");
        failures++;
        finish_test();
    end

    initial begin
        int n1;
        int n2;
        seed = 10960;
        failures = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        strb_sel = 4'hF;
        watchdog_timeout_n = 1'b1;
        for (int g = 0; g < 4; g++) begin
            pin_in[g] = 8'h00;
            stored[g] = 8'h00;
        end
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        check_reset_values();
        $display("test reset_values done");
        apb(1'b0, 12'h004, 8'h00);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        apb(1'b1, 12'h0C1, 8'hFF);
        chk("misaligned err", 1, err);
        // low byte strobe off: no write, no error
        strb_sel = 4'hE;
        apb(1'b1, ba(standby_pin_pkg::IDX_ACTIVATION), 8'h0F);
        strb_sel = 4'hF;
        chk("strobe off err", 0, err);
        rdchk("activation", standby_pin_pkg::IDX_ACTIVATION, 8'h00);
        $display("test unmapped done");
        for (int i = 0; i < 24; i++) begin
            rand_step();
        end
        $display("test pin_groups done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ba(standby_pin_pkg::IDX_SUSPEND_MODE), {m[1:0], 6'h3F});
            repeat (3) @(posedge pclk);
            rdchk("mode", standby_pin_pkg::IDX_SUSPEND_MODE, {m[1:0], 6'h00});
            chk("led oe_n", m == 0, led_oe_n);
            if (m == 1) begin
                chk("led level", 0, led_out);
            end
            if (m >= 2) begin
                levels(n1, n2);
                chk("led level time", m == 2 ? HALF : 4 * HALF, n1);
                chk("led other level time", m == 2 ? HALF : 4 * HALF, n2);
            end
        end
        $display("test indicator_modes done");
        apb(1'b1, ba(standby_pin_pkg::IDX_ACTIVATION), 8'h00);
        apb(1'b1, ba(standby_pin_pkg::IDX_SUSPEND_MODE), 8'h40);
        apb(1'b1, ba(standby_pin_pkg::IDX_FUNC_SELECT), 8'hFF);
        rdchk("func select", standby_pin_pkg::IDX_FUNC_SELECT, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            watchdog_timeout_n <= 1'($random(seed));
            repeat (4) @(posedge pclk);
            chk("even pins", watchdog_timeout_n ? 8'h55 : 8'h00, pin_out[2] & 8'h55);
            chk("odd pins", 8'h00, pin_out[2] & 8'hAA);
            chk("c oe_n", 8'h00, pin_oe_n[2]);
        end
        apb(1'b1, ba(standby_pin_pkg::IDX_SUSPEND_MODE), 8'h00);
        repeat (4) @(posedge pclk);
        chk("odd oe_n", 8'hAA, pin_oe_n[2]);
        apb(1'b1, ba(standby_pin_pkg::IDX_FUNC_SELECT), 8'h00);
        repeat (3) @(posedge pclk);
        chk("c released", 8'hFF, pin_oe_n[2]);
        $display("test func_select done");
        for (int g = 0; g < 4; g++) begin
            pin_in[g] <= 8'h00;
            stored[g] = 8'h00;
        end
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check_reset_values();
        $display("test second_reset done");
        finish_test();
    end
endmodule
